/* File: rtl/ftc_top.v */
// Top of the fast threshold counter: Avalon-MM register slave, one
// single-pulse counter and two quadrature counters on fixed pins.
// Assumes pins are asynchronous and count frequencies stay below 5 kHz.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "ftc_consts.vh"

module ftc_top (
  input wire clk_sys,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire fast_pulse_pin,
  input wire [3:0] quad_pin,
  output wire [2:0] upper_reached_flag,
  output wire [2:0] lower_reached_flag,
  output wire [2:0] null_value_flag,
  output wire [2:0] range_carry_flag,
  output reg run_active_q
);

  // Merge write data into an old value under the byte enables.
  // Lanes whose enable is low keep their old byte.
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer i;
    begin
      be_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Decode one quadrature step from {B,A} before and after.
  // Returns {down, up}; a jump of both channels is ignored.
  // Walking the table round once gives four counts per period.
  function [1:0] quad_step;
    input [1:0] prev_ba;
    input [1:0] cur_ba;
    begin
      case ({prev_ba, cur_ba})
        4'b0001: quad_step = 2'b01;
        4'b0111: quad_step = 2'b01;
        4'b1110: quad_step = 2'b01;
        4'b1000: quad_step = 2'b01;
        4'b0010: quad_step = 2'b10;
        4'b1011: quad_step = 2'b10;
        4'b1101: quad_step = 2'b10;
        4'b0100: quad_step = 2'b10;
        default: quad_step = 2'b00;
      endcase
    end
  endfunction

  // Register storage, one entry per unit.
  reg [`FTC_CTRL_W-1:0] ctrl_q [0:`FTC_UNITS-1];
  reg [31:0] start_q [0:`FTC_UNITS-1];
  reg [31:0] upper_q [0:`FTC_UNITS-1];
  reg [31:0] lower_q [0:`FTC_UNITS-1];
  reg [2:0] carry_seen_q;
  reg [2:0] load_prev_q;
  reg [2:0] restore_q;
  reg [31:0] restore_val_q [0:`FTC_UNITS-1];
  reg run_prev_q;
  reg [4:0] pins_prev_q;
  reg [31:0] rd_d;

  wire [4:0] pins_s;
  wire [95:0] count_flat;
  wire [6:0] byte_addr;
  wire [1:0] unit_sel;
  wire [4:0] reg_off;
  wire wr_take;
  wire run_start;
  wire fast_edge;
  wire [1:0] quad1_step;
  wire [1:0] quad2_step;
  wire [2:0] count_ok;
  wire [2:0] step_up;
  wire [2:0] step_dn;
  wire [2:0] clear_req;
  wire [2:0] load_req;

  integer u;
  genvar g;

  // Pins go through two flops before anything looks at them.
  // Bit 4 is the fast pulse pin, bits 3 to 0 the channel pins.
  ftc_sync #(
    .W(5)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({fast_pulse_pin, quad_pin}),
    .sync_out(pins_s)
  );

  // Previous synchronised pin levels for edge detection.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_q <= 5'h00;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  // Every edge is seen at 100 MHz; a 5 kHz source leaves thousands of
  // cycles between edges, so no extra filtering is needed.
  assign fast_edge = pins_s[4] & ~pins_prev_q[4];
  // Pins 0/1 are channel A/B of unit one, pins 2/3 of unit two.
  assign quad1_step = quad_step(pins_prev_q[1:0], pins_s[1:0]);
  assign quad2_step = quad_step(pins_prev_q[3:2], pins_s[3:2]);

  // Counting needs run mode and, when the option asks, the enable bit.
  // Stop mode freezes every unit, whatever its enable bit says.
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ok
      assign count_ok[g] = run_active_q &
        (~ctrl_q[g][`FTC_CTRL_EN_OPT] | ctrl_q[g][`FTC_CTRL_EN]);
    end
  endgenerate

  // Single pulse front end: direction bit low counts up.
  assign step_up[0] = fast_edge & ~ctrl_q[0][`FTC_CTRL_DIR] &
    count_ok[0];
  assign step_dn[0] = fast_edge & ctrl_q[0][`FTC_CTRL_DIR] &
    count_ok[0];
  // Quadrature front ends count all four edges of each period.
  assign step_up[1] = quad1_step[0] & count_ok[1];
  assign step_dn[1] = quad1_step[1] & count_ok[1];
  assign step_up[2] = quad2_step[0] & count_ok[2];
  assign step_dn[2] = quad2_step[1] & count_ok[2];

  // Entering run from stop clears units that do not retain their count.
  // Retaining units go on from the count they held while stopped.
  assign run_start = run_active_q & ~run_prev_q;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_req
      assign clear_req[g] = ctrl_q[g][`FTC_CTRL_CLEAR] |
        (run_start & ~ctrl_q[g][`FTC_CTRL_RETAIN]);
      assign load_req[g] = ctrl_q[g][`FTC_CTRL_LOAD] &
        ~load_prev_q[g];
    end
  endgenerate

  // Three identical count units.
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_unit
      ftc_count_core u_core (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .count_up(step_up[g]),
        .count_down(step_dn[g]),
        .clear_to_zero(clear_req[g]),
        .load_start_value(load_req[g]),
        .restore(restore_q[g]),
        .start_value(start_q[g]),
        .restore_value(restore_val_q[g]),
        .upper_limit_value(upper_q[g]),
        .lower_limit_value(lower_q[g]),
        .actual_count(count_flat[g*32 +: 32]),
        .upper_reached_flag(upper_reached_flag[g]),
        .lower_reached_flag(lower_reached_flag[g]),
        .null_value_flag(null_value_flag[g]),
        .range_carry_flag(range_carry_flag[g])
      );
    end
  endgenerate

  // Address split: two bits pick the unit, five bits the register.
  assign byte_addr = {avs_address, 2'b00};
  assign unit_sel = byte_addr[6:5];
  assign reg_off = byte_addr[4:0];
  assign wr_take = avs_write & ~avs_waitrequest;

  // Read multiplexer; unmapped offsets read as zero.
  // Status bit 3 is sticky, since the live carry pulse is too short to read.
  always @* begin
    rd_d = 32'h00000000;
    if (unit_sel == `FTC_UNIT_GLOBAL) begin
      if (reg_off == `FTC_OFF_RUN) begin
        rd_d = {31'h00000000, run_active_q};
      end
    end else begin
      case (reg_off)
        `FTC_OFF_CTRL: begin
          rd_d = {26'h0000000, ctrl_q[unit_sel]};
        end
        `FTC_OFF_START: begin
          rd_d = start_q[unit_sel];
        end
        `FTC_OFF_UPPER: begin
          rd_d = upper_q[unit_sel];
        end
        `FTC_OFF_LOWER: begin
          rd_d = lower_q[unit_sel];
        end
        `FTC_OFF_COUNT: begin
          rd_d = count_flat[unit_sel*32 +: 32];
        end
        `FTC_OFF_STATUS: begin
          rd_d = {28'h0000000, carry_seen_q[unit_sel],
            null_value_flag[unit_sel], lower_reached_flag[unit_sel],
            upper_reached_flag[unit_sel]};
        end
        default: begin
          rd_d = 32'h00000000;
        end
      endcase
    end
  end

  // Bus handshake: one wait cycle, then the access is taken at the edge
  // where waitrequest is seen low. Idle waitrequest stays high, which
  // keeps the answer time fixed at two edges.
  // Read data are loaded as waitrequest falls and then stand unchanged.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= rd_d;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Run mode and its previous value for the start edge.
  // Only byte lane 0 carries the run bit.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_active_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_active_q;
      if (wr_take && unit_sel == `FTC_UNIT_GLOBAL &&
          reg_off == `FTC_OFF_RUN && avs_byteenable[0]) begin
        run_active_q <= avs_writedata[0];
      end
    end
  end

  // Unit registers. The count may be written back only while stopped,
  // which is how software restores a count saved before power loss.
  // restore_q is a one-cycle strobe into the core.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (u = 0; u < 3; u = u + 1) begin
        ctrl_q[u] <= `FTC_CTRL_RST;
        start_q[u] <= `FTC_START_RST;
        upper_q[u] <= `FTC_UPPER_RST;
        lower_q[u] <= `FTC_LOWER_RST;
        restore_val_q[u] <= 32'h00000000;
      end
      carry_seen_q <= 3'h0;
      load_prev_q <= 3'h0;
      restore_q <= 3'h0;
    end else begin
      for (u = 0; u < 3; u = u + 1) begin
        load_prev_q[u] <= ctrl_q[u][`FTC_CTRL_LOAD];
        restore_q[u] <= 1'b0;
        if (wr_take && unit_sel == u) begin
          case (reg_off)
            `FTC_OFF_CTRL: begin
              // Every control bit sits in byte lane 0.
              if (avs_byteenable[0]) begin
                ctrl_q[u] <= avs_writedata[`FTC_CTRL_W-1:0];
              end
            end
            `FTC_OFF_START: begin
              start_q[u] <= be_merge(start_q[u], avs_writedata,
                avs_byteenable);
            end
            `FTC_OFF_UPPER: begin
              upper_q[u] <= be_merge(upper_q[u], avs_writedata,
                avs_byteenable);
            end
            `FTC_OFF_LOWER: begin
              lower_q[u] <= be_merge(lower_q[u], avs_writedata,
                avs_byteenable);
            end
            `FTC_OFF_COUNT: begin
              // A write while running is dropped; it would race the pins.
              if (!run_active_q) begin
                restore_q[u] <= 1'b1;
                restore_val_q[u] <= be_merge(count_flat[u*32 +: 32],
                  avs_writedata, avs_byteenable);
              end
            end
            default: begin
            end
          endcase
        end
        // Sticky carry: a new carry pulse wins over a write-one clear.
        // Software clears it by writing a one to status bit 3.
        if (range_carry_flag[u]) begin
          carry_seen_q[u] <= 1'b1;
        end else if (wr_take && unit_sel == u &&
            reg_off == `FTC_OFF_STATUS && avs_byteenable[0] &&
            avs_writedata[`FTC_ST_CARRY]) begin
          carry_seen_q[u] <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: rtl/ftc_consts.vh */
// Constants for the fast threshold up/down counter block.
// Assumes byte addressing of a 32-bit Avalon-MM register window.
`ifndef FTC_CONSTS_VH
`define FTC_CONSTS_VH

// Unit windows: fast pulse, quadrature one, quadrature two, global.
`define FTC_UNITS 3
`define FTC_UNIT_GLOBAL 2'h3

// Register offsets inside one unit window.
`define FTC_OFF_CTRL 5'h00
`define FTC_OFF_START 5'h04
`define FTC_OFF_UPPER 5'h08
`define FTC_OFF_LOWER 5'h0c
`define FTC_OFF_COUNT 5'h10
`define FTC_OFF_STATUS 5'h14
// Offset of the run register inside the global window.
`define FTC_OFF_RUN 5'h00

// Control register fields.
`define FTC_CTRL_EN_OPT 0
`define FTC_CTRL_EN 1
`define FTC_CTRL_DIR 2
`define FTC_CTRL_RETAIN 3
`define FTC_CTRL_CLEAR 4
`define FTC_CTRL_LOAD 5
`define FTC_CTRL_W 6

// Status register fields.
`define FTC_ST_UPPER 0
`define FTC_ST_LOWER 1
`define FTC_ST_ZERO 2
`define FTC_ST_CARRY 3

// Reset values.
`define FTC_CTRL_RST 6'h00
`define FTC_START_RST 32'h00000000
`define FTC_UPPER_RST 32'h7fffffff
`define FTC_LOWER_RST 32'h00000000

// Signed 32-bit count range.
`define FTC_CNT_MAX 32'h7fffffff
`define FTC_CNT_MIN 32'h80000000

// Timing: system clock and the highest permitted count frequency.
`define FTC_CLK_HZ 100000000
`define FTC_MAX_COUNT_HZ 5000
// Least clock cycles between two quadrature edges at that frequency.
`define FTC_MIN_EDGE_CYC (`FTC_CLK_HZ / (`FTC_MAX_COUNT_HZ * 4))

`endif

/* File: rtl/ftc_sync.v */
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each pin is a slow level compared with the clock.
`timescale 1ns/1ps

module ftc_sync #(
  parameter W = 5
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: rtl/ftc_count_core.v */
// One signed 32-bit up/down count unit with threshold and range flags.
// Assumes count_up and count_down are one-cycle pulses from the top.
`timescale 1ns/1ps
`include "ftc_consts.vh"

module ftc_count_core (
  input wire clk_sys,
  input wire rst_n,
  input wire count_up,
  input wire count_down,
  input wire clear_to_zero,
  input wire load_start_value,
  input wire restore,
  input wire [31:0] start_value,
  input wire [31:0] restore_value,
  input wire [31:0] upper_limit_value,
  input wire [31:0] lower_limit_value,
  output reg [31:0] actual_count,
  output reg upper_reached_flag,
  output reg lower_reached_flag,
  output reg null_value_flag,
  output reg range_carry_flag
);

  reg [31:0] count_d;
  reg carry_d;

  // Next count: clear beats load, load beats restore, all beat counting.
  always @* begin
    count_d = actual_count;
    carry_d = 1'b0;
    if (clear_to_zero) begin
      count_d = 32'h00000000;
    end else if (load_start_value) begin
      count_d = start_value;
    end else if (restore) begin
      count_d = restore_value;
    end else if (count_up && !count_down) begin
      // A step past the range end is refused; the old count stays.
      if (actual_count == `FTC_CNT_MAX) begin
        carry_d = 1'b1;
      end else begin
        count_d = actual_count + 32'h00000001;
      end
    end else if (count_down && !count_up) begin
      if (actual_count == `FTC_CNT_MIN) begin
        carry_d = 1'b1;
      end else begin
        count_d = actual_count - 32'h00000001;
      end
    end
  end

  // Flags are taken from the next count so they line up with it.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      actual_count <= 32'h00000000;
      upper_reached_flag <= 1'b0;
      lower_reached_flag <= 1'b1;
      null_value_flag <= 1'b1;
      range_carry_flag <= 1'b0;
    end else begin
      actual_count <= count_d;
      upper_reached_flag <=
        ($signed(count_d) >= $signed(upper_limit_value));
      lower_reached_flag <=
        ($signed(count_d) <= $signed(lower_limit_value));
      null_value_flag <= (count_d == 32'h00000000);
      range_carry_flag <= carry_d;
    end
  end

endmodule

/* File: verif/ftc_enc_src.sv */
// Pulse source and two quadrature encoders that drive the counter pins.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps

module ftc_enc_src (
  input wire clk_sys,
  output logic fast_pulse_pin,
  output logic [3:0] quad_pin
);
  // Encoders rest at a level; a real shaft stays where it stopped.
  initial begin
    fast_pulse_pin = 1'b0;
    quad_pin = 4'h0;
  end

  // Square pulses with equal high and low time of gap cycles each.
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      fast_pulse_pin <= 1'b1;
      repeat (gap) @(posedge clk_sys);
      fast_pulse_pin <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
  endtask

  // One quarter period per step; up walks {B,A} 00,01,11,10.
  task automatic quad(input int u, input bit up, input int n, input int gap);
    logic [1:0] ba;
    repeat (n) begin
      ba = quad_pin[2*u+:2];
      quad_pin[2*u+:2] <= up ? {ba[0], ~ba[1]} : {~ba[0], ba[1]};
      repeat (gap) @(posedge clk_sys);
    end
  endtask
endmodule

/* File: verif/ftc_top_assertions.sv */
// Port checks for the fast threshold counter top.
// Assumes one clock domain and the one-wait-state register slave.
`timescale 1ns/1ps

module ftc_top_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire fast_pulse_pin,
  input wire [3:0] quad_pin,
  input wire [2:0] upper_reached_flag,
  input wire [2:0] lower_reached_flag,
  input wire [2:0] null_value_flag,
  input wire [2:0] range_carry_flag,
  input wire run_active_q
);
  logic [4:0] pins_q;
  logic [3:0] pin_age_q, pin_age_d, wr_age_q, wr_age_d;
  wire [8:0] lvl = {upper_reached_flag, lower_reached_flag, null_value_flag};
  wire pin_chg = {fast_pulse_pin, quad_pin} != pins_q;

  // Ages saturate at 15 so a long quiet spell never wraps to look busy.
  always @* begin
    pin_age_d = pin_chg ? 4'h0 : pin_age_q + {3'h0, pin_age_q != 4'hf};
    wr_age_d = avs_write ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
  end

  // Ages restart at reset, so no check leans on history before it.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= 5'h00;
      pin_age_q <= 4'h0;
      wr_age_q <= 4'h0;
    end else begin
      pins_q <= {fast_pulse_pin, quad_pin};
      pin_age_q <= pin_age_d;
      wr_age_q <= wr_age_d;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_wait_answer: assert property (s_request |=> s_answer)
    else $error("waitrequest not low for exactly one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_rdata_hold: assert property ($changed(avs_readdata) |->
    $past(avs_read && avs_waitrequest))
    else $error("read data moved without a read");
  a_run_by_write: assert property (
    $changed(run_active_q) |-> $past(avs_write && !avs_waitrequest &&
    avs_address == 5'h18 && avs_byteenable[0]))
    else $error("run bit moved without a run write");
  a_carry_single: assert property (
    (range_carry_flag & $past(range_carry_flag)) == 3'h0)
    else $error("carry held longer than one cycle");
  a_carry_cause: assert property (
    range_carry_flag != 3'h0 |-> pin_age_q <= 4'h5)
    else $error("carry without a recent pin edge");
  a_flags_quiet: assert property (
    pin_age_q >= 4'h8 && wr_age_q >= 4'h8 |-> $stable(lvl))
    else $error("flags moved with no cause");
  a_stop_hold: assert property (
    !run_active_q && wr_age_q >= 4'h8 |-> $stable(lvl))
    else $error("flags moved while stopped");
endmodule

bind ftc_top ftc_top_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fast_pulse_pin(fast_pulse_pin), .quad_pin(quad_pin),
  .upper_reached_flag(upper_reached_flag),
  .lower_reached_flag(lower_reached_flag),
  .null_value_flag(null_value_flag),
  .range_carry_flag(range_carry_flag), .run_active_q(run_active_q)
);

/* File: verif/tb_top.sv */
// Self-checking bench: register tasks, pin source and expected counts.
// Assumes the design, the checker and the pin source are compiled first.
`timescale 1ns/1ps
`include "ftc_consts.vh"

module tb_top;
  logic clk_sys, rst_n, avs_read, avs_write;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, rdv, r;
  logic [3:0] avs_byteenable;
  logic signed [31:0] cnt [3], ul [3], ll [3];
  wire [31:0] avs_readdata;
  wire avs_waitrequest, fast_pulse_pin, run_active_q;
  wire [3:0] quad_pin;
  wire [2:0] upper_reached_flag, lower_reached_flag;
  wire [2:0] null_value_flag, range_carry_flag;
  int mismatches, cmp_count, n;

  ftc_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fast_pulse_pin(fast_pulse_pin), .quad_pin(quad_pin),
    .upper_reached_flag(upper_reached_flag),
    .lower_reached_flag(lower_reached_flag),
    .null_value_flag(null_value_flag),
    .range_carry_flag(range_carry_flag), .run_active_q(run_active_q)
  );
  ftc_enc_src src (
    .clk_sys(clk_sys), .fast_pulse_pin(fast_pulse_pin), .quad_pin(quad_pin)
  );

  // Free-running 100 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flags(input int u);
    logic [2:0] e, g;
    e = {cnt[u] >= ul[u], cnt[u] <= ll[u], cnt[u] == 0};
    g = {upper_reached_flag[u], lower_reached_flag[u], null_value_flag[u]};
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error flags of unit %0d expected %b seen %b", u, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases.
  task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 100) begin
      mismatches++;
      $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
      conclude();
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h00000000);
    chk_word(nm, e, rdv);
  endtask

  function automatic logic [4:0] ad(input int u, input logic [4:0] off);
    return 5'(u * 8 + off / 4);
  endfunction

  // Expected step: a step past either end of the range leaves the count.
  function automatic logic signed [31:0] stp(input logic signed [31:0] v,
                                             input bit up);
    if (up) return (v == `FTC_CNT_MAX) ? v : v + 1;
    return (v == `FTC_CNT_MIN) ? v : v - 1;
  endfunction

  task automatic see(input int u);
    rd(ad(u, `FTC_OFF_COUNT), cnt[u], "count");
    chk_flags(u);
  endtask

  task automatic pls(input int k, input bit up);
    src.pulses(k, 6);
    repeat (k) cnt[0] = stp(cnt[0], up);
  endtask

  task automatic qd(input int u, input bit up, input int k, input int gap);
    src.quad(u - 1, up, k, gap);
    repeat (k) cnt[u] = stp(cnt[u], up);
  endtask

  // Main sequence; the slow encoder burst dominates the run time.
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h24823291));
    for (int u = 0; u < 3; u++) begin
      cnt[u] = 0;
      ul[u] = `FTC_UPPER_RST;
      ll[u] = `FTC_LOWER_RST;
    end
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int u = 0; u < 3; u++) begin
      rd(ad(u, `FTC_OFF_CTRL), `FTC_CTRL_RST, "ctrl");
      rd(ad(u, `FTC_OFF_UPPER), `FTC_UPPER_RST, "upper");
      rd(ad(u, `FTC_OFF_LOWER), `FTC_LOWER_RST, "lower");
      see(u);
    end
    bus(1'b1, 5'h07, 32'hffffffff);
    rd(5'h07, 32'h00000000, "unmapped");
    avs_byteenable <= 4'h1;
    bus(1'b1, ad(0, `FTC_OFF_START), 32'h12345678);
    avs_byteenable <= 4'hf;
    rd(ad(0, `FTC_OFF_START), 32'h00000078, "start lanes");
    src.pulses(3, 6);
    src.quad(0, 1'b1, 2, 6);
    see(0);
    see(1);
    bus(1'b1, ad(`FTC_UNIT_GLOBAL, `FTC_OFF_RUN), 32'h00000001);
    chk_word("run", 32'h00000001, {31'h0, run_active_q});
    n = $urandom_range(9, 3);
    pls(n, 1'b1);
    see(0);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000004);
    pls(n + 2, 1'b0);
    see(0);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000005);
    src.pulses(2, 6);
    see(0);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000007);
    pls(2, 1'b0);
    see(0);
    for (int u = 1; u < 3; u++) begin
      ul[u] = $urandom_range(6, 2);
      ll[u] = -2;
      bus(1'b1, ad(u, `FTC_OFF_UPPER), ul[u]);
      bus(1'b1, ad(u, `FTC_OFF_LOWER), ll[u]);
      repeat (4) begin
        qd(u, 1'($urandom_range(1, 0)), $urandom_range(7, 1), 6);
        see(1);
        see(2);
      end
    end
    qd(1, 1'b1, 4, `FTC_MIN_EDGE_CYC);
    see(1);
    bus(1'b1, ad(0, `FTC_OFF_START), `FTC_CNT_MAX);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000020);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000000);
    cnt[0] = `FTC_CNT_MAX;
    see(0);
    pls(2, 1'b1);
    see(0);
    rd(ad(0, `FTC_OFF_STATUS), 32'h00000009, "status");
    bus(1'b1, ad(0, `FTC_OFF_STATUS), 32'h00000008);
    rd(ad(0, `FTC_OFF_STATUS), 32'h00000001, "status");
    bus(1'b1, ad(0, `FTC_OFF_START), `FTC_CNT_MIN);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000024);
    cnt[0] = `FTC_CNT_MIN;
    pls(1, 1'b0);
    see(0);
    rd(ad(0, `FTC_OFF_STATUS), 32'h0000000a, "status");
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000010);
    cnt[0] = 0;
    see(0);
    src.pulses(2, 6);
    see(0);
    bus(1'b1, ad(0, `FTC_OFF_CTRL), 32'h00000000);
    bus(1'b1, ad(1, `FTC_OFF_CTRL), 32'h00000008);
    bus(1'b1, ad(2, `FTC_OFF_CTRL), 32'h00000008);
    bus(1'b1, ad(`FTC_UNIT_GLOBAL, `FTC_OFF_RUN), 32'h00000000);
    r = $urandom;
    bus(1'b1, ad(2, `FTC_OFF_COUNT), r);
    repeat (2) @(posedge clk_sys);
    cnt[2] = r;
    see(2);
    bus(1'b1, ad(`FTC_UNIT_GLOBAL, `FTC_OFF_RUN), 32'h00000001);
    cnt[0] = 0;
    for (int u = 0; u < 3; u++) see(u);
    qd(2, 1'b0, 3, 6);
    see(2);
    bus(1'b1, ad(1, `FTC_OFF_COUNT), 32'h00000055);
    see(1);
    conclude();
  end

  // Watchdog sized well above the roughly 21000 cycles the tests need.
  initial begin
    #600000;
    mismatches++;
    conclude();
  end
endmodule
